// file: rtl/tmsr_pkg.sv
// package for the timer setup register bank
package tmsr_pkg;
  localparam logic [3:0] FRAME_NUM = 4'h4;
  localparam logic [15:0] ADDR_SETUP = 16'h1040;
  localparam logic [15:0] ADDR_START = 16'h1041;
  localparam logic [15:0] ADDR_END = 16'h1042;
  localparam logic [15:0] ADDR_CIRCULAR_BUFFER_POINTER = 16'h1043;
  localparam logic [15:0] ADDR_RSVD = 16'h1044;
  localparam logic [15:0] ADDR_SERCTL = 16'h1045;
  localparam logic [15:0] ADDR_RXDATA = 16'h1046;
  localparam logic [15:0] ADDR_TXDATA = 16'h1047;
  localparam logic [15:0] ADDR_OUTPUT_PIN_STATE = 16'h1048;
  localparam logic [15:0] ADDR_COMMAND_AREA_INT_FLAGS = 16'h1049;
  localparam logic [15:0] ADDR_CAPTURE_CTL_PINS_1_2 = 16'h104a;
  localparam logic [15:0] ADDR_CAPTURE_CTL_PINS_3_4 = 16'h104b;
  localparam logic [15:0] ADDR_CAPTURE_CTL_PINS_5_6 = 16'h104c;
  localparam logic [15:0] ADDR_CAPTURE_PRESCALE_CTL = 16'h104d;
  localparam logic [15:0] ADDR_WDKEY = 16'h104e;
  localparam logic [15:0] ADDR_PRIMODE = 16'h104f;
  // setup register field positions
  localparam int BIT_OVF_EN = 7;
  localparam int BIT_OVF_FLAG = 6;
  localparam int BIT_AREA_EN = 5;
  localparam int BIT_FAST = 4;
  // start register field positions
  localparam int BIT_AREA_IRQ_EN = 7;
  localparam int START_LSB = 2;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] START_RST = 8'h00;
  localparam logic [7:0] START_FORCE = 8'hc3;
  localparam logic [7:0] START_KEEP = 8'h3c;
  localparam logic [7:0] PRIV_MASK = 8'h1f;
  localparam logic [7:0] RSVD_READ = 8'h00;
  localparam logic [3:0] PREDIV_CNT = 4'h7;
  localparam logic [8:0] AREA_HI_LARGE = 9'h100;
  typedef struct packed {
    logic [1:0] rstn_sync;
    logic [7:0] setup;
    logic [7:0] start;
    logic [2:0] prediv;
    logic [3:0] pre_cnt;
    logic tick;
    logic [7:0] rdata;
  } tmsr_state_s;
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic priv;
  } tmsr_bus_s;
endpackage : tmsr_pkg

// file: rtl/tmsr_setup_regs.sv
// setup and command area start registers of the timer module
`timescale 1ns/1ps
module tmsr_setup_regs
  import tmsr_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1  // larger-memory variant places area in page one
) (
  input wire logic i_sys_clk,  // system clock, 200 MHz
  input wire logic i_rstn,  // async reset, active low
  input wire tmsr_bus_s i_bus,  // processor peripheral access
  input wire logic i_overflow,  // default timer overflow pulse
  output logic [7:0] o_rdata,  // read data, registered
  output logic o_overflow_irq,  // overflow interrupt request
  output logic o_command_area_enable,  // execute command area
  output logic o_command_area_irq_enable,  // command area irq enable
  output logic [8:0] o_area_start,  // command area start address
  output logic o_timebase_tick  // one pulse per module time base
);
  tmsr_state_s s_q;
  tmsr_state_s s_d;
  logic rst_n;
  logic hit_setup;
  logic hit_start;
  logic pre_en;
  logic [3:0] pre_top;
  logic [7:0] wr_setup;

  assign rst_n = s_q.rstn_sync[1];
  assign hit_setup = (i_bus.addr == ADDR_SETUP) && (i_bus.addr[7:4] == FRAME_NUM);
  assign hit_start = (i_bus.addr == ADDR_START) && (i_bus.addr[7:4] == FRAME_NUM);
  // code zero behaves as code one
  assign pre_top = (s_q.setup[3:0] == 4'h0) ? 4'h1 : s_q.setup[3:0];
  assign pre_en = s_q.setup[BIT_FAST] | (s_q.prediv == PREDIV_CNT[2:0]);

  always_comb begin
    s_d = s_q;
    s_d.rstn_sync = {s_q.rstn_sync[0], 1'b1};
    wr_setup = i_bus.wdata;
    // privileged bits hold outside privilege mode
    if (!i_bus.priv) begin
      wr_setup = (i_bus.wdata & ~PRIV_MASK) | (s_q.setup & PRIV_MASK);
    end
    if (i_bus.wr && hit_setup) begin
      s_d.setup[BIT_OVF_EN] = wr_setup[BIT_OVF_EN];
      s_d.setup[BIT_AREA_EN] = wr_setup[BIT_AREA_EN];
      s_d.setup[4:0] = wr_setup[4:0];
      s_d.setup[BIT_OVF_FLAG] = s_q.setup[BIT_OVF_FLAG] & wr_setup[BIT_OVF_FLAG];
    end
    // set wins over a clear in the same cycle
    if (i_overflow) begin
      s_d.setup[BIT_OVF_FLAG] = 1'b1;
    end
    // start register stores enable and code only
    if (i_bus.wr && hit_start) begin
      s_d.start = i_bus.wdata & (START_KEEP | 8'h80);
    end
    // divide by eight stage, free running in slow mode
    s_d.prediv = s_q.setup[BIT_FAST] ? 3'h0 : s_q.prediv + 3'h1;
    s_d.tick = 1'b0;
    // slow rate is the fast count stepped by the predivider
    if (pre_en) begin
      if (s_q.pre_cnt >= pre_top) begin
        s_d.pre_cnt = 4'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 4'h1;
      end
    end
    s_d.rdata = RSVD_READ;
    if (i_bus.rd && hit_setup) begin
      s_d.rdata = s_q.setup;
    end else if (i_bus.rd && hit_start) begin
      s_d.rdata = s_q.start;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else if (!rst_n) begin
      s_q <= '0;
      s_q.rstn_sync <= {s_q.rstn_sync[0], 1'b1};
      s_q.setup <= SETUP_RST;
      s_q.start <= START_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_overflow_irq = s_q.setup[BIT_OVF_FLAG] & s_q.setup[BIT_OVF_EN];
  assign o_command_area_enable = s_q.setup[BIT_AREA_EN];
  assign o_command_area_irq_enable = s_q.start[BIT_AREA_IRQ_EN];
  // forced bits complete the start address
  assign o_area_start = (LARGE_MEM ? AREA_HI_LARGE : 9'h000) |
                        {1'b0, (s_q.start & START_KEEP) | START_FORCE};
  assign o_timebase_tick = s_q.tick;

  AST_IRQ: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_overflow && s_q.setup[BIT_OVF_EN] && !(i_bus.wr && hit_setup)) |=> o_overflow_irq)
    else $error("irq not raised on overflow");
  AST_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i_overflow |=> s_q.setup[6])
    else $error("overflow flag not set");
  AST_PRIV: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.wr && hit_setup && !i_bus.priv) |=> $stable(s_q.setup[4:0]))
    else $error("privileged bits changed");
  AST_ONE_KEEPS: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.wr && hit_setup && i_bus.wdata[6] && s_q.setup[6]) |=> s_q.setup[6])
    else $error("flag lost on written one");
  AST_ZERO_CLR: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.wr && hit_setup && !i_bus.wdata[6] && !i_overflow) |=> !s_q.setup[6])
    else $error("flag not cleared");
  AST_START_FORCE: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_area_start[7:6] == 2'b11 && o_area_start[1:0] == 2'b11)
    else $error("start forced bits wrong");
  AST_RSVD: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.rd && hit_start) |=> (o_rdata[6] == 1'b0 && o_rdata[1:0] == 2'b00))
    else $error("reserved bits nonzero");
  sequence seq_fast_code1;
    s_q.setup[4:0] == 5'h11 && o_timebase_tick;
  endsequence
  AST_FAST_DIV2: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (seq_fast_code1 ##1 s_q.setup[4:0] == 5'h11) |-> !o_timebase_tick ##1 1'b1)
    else $error("fast divide wrong");
  AST_AREA_EN: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.wr && hit_setup) |=> o_command_area_enable == $past(i_bus.wdata[5]))
    else $error("area enable not written");
  AST_IRQEN: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.wr && hit_start) |=> o_command_area_irq_enable == $past(i_bus.wdata[7]))
    else $error("area irq enable not written");
  sequence seq_setup_wr;
    i_bus.wr && hit_setup;
  endsequence
  AST_IRQ_MASK: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (seq_setup_wr ##0 !i_bus.wdata[BIT_OVF_EN]) |=> !o_overflow_irq)
    else $error("irq not masked");
  AST_PRIV_WR: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (seq_setup_wr ##0 i_bus.priv) |=> s_q.setup[4:0] == $past(i_bus.wdata[4:0]))
    else $error("privileged write lost");
  // flag moves only on an overflow or a setup write
  AST_FLAG_HOLD: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (!i_overflow && !(i_bus.wr && hit_setup)) |=> $stable(s_q.setup[BIT_OVF_FLAG]))
    else $error("flag changed on its own");
  AST_SETUP_HOLD: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !(i_bus.wr && hit_setup) |=> $stable({s_q.setup[7], s_q.setup[5:0]}))
    else $error("setup changed without write");
  AST_START_HOLD: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !(i_bus.wr && hit_start) |=> $stable(s_q.start))
    else $error("start changed without write");
  AST_START_CODE: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.wr && hit_start) |=> (o_area_start[5:2] == $past(i_bus.wdata[5:2]) &&
      o_area_start[8] == LARGE_MEM))
    else $error("start code not applied");
  AST_UNMAPPED: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (i_bus.rd && !hit_setup && !hit_start) |=> o_rdata == RSVD_READ)
    else $error("unmapped read not zero");
  // shortest divide is two, so a tick never repeats back to back
  AST_TICK_ONE: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    o_timebase_tick |=> !o_timebase_tick)
    else $error("tick longer than one cycle");
endmodule : tmsr_setup_regs

// file: verification/tmsr_setup_regs_tb.sv
// self-checking bench for the timer setup register bank
`timescale 1ns/1ps
module tmsr_setup_regs_tb;
  import tmsr_pkg::*;
  logic clk = 0, rstn = 0, ovf = 0, irq, area_en, area_irq_en, tick;
  tmsr_bus_s bus = '0;
  logic [7:0] rdata, v, w;
  logic [8:0] area_start, area_start_s;
  int fail_count = 0, check_count = 0;
  tmsr_setup_regs #(.LARGE_MEM(1'b1)) uut (.i_sys_clk(clk), .i_rstn(rstn), .i_bus(bus),
    .i_overflow(ovf), .o_rdata(rdata), .o_overflow_irq(irq), .o_command_area_enable(area_en),
    .o_command_area_irq_enable(area_irq_en), .o_area_start(area_start), .o_timebase_tick(tick));
  // smaller-memory variant, only its start address is watched
  tmsr_setup_regs #(.LARGE_MEM(1'b0)) uut_small (.i_sys_clk(clk), .i_rstn(rstn), .i_bus(bus),
    .i_overflow(ovf), .o_rdata(), .o_overflow_irq(), .o_command_area_enable(),
    .o_command_area_irq_enable(), .o_area_start(area_start_s), .o_timebase_tick());
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one strobe cycle; read data lands at the edge that samples rd
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic p, input bit r);
    @(posedge clk) #1;
    bus.addr = a; bus.wdata = d; bus.priv = p; bus.rd = r; bus.wr = !r;
    @(posedge clk) #1;
    bus.rd = 0; bus.wr = 0; v = rdata;
  endtask : acc
  task automatic pulse_ovf;
    @(posedge clk) #1 ovf = 1;
    @(posedge clk) #1 ovf = 0;
  endtask : pulse_ovf
  function automatic int per(input logic [4:0] c);
    return ((c[3:0] == 4'h0 ? 1 : int'(c[3:0])) + 1) * (c[4] ? 1 : 8);
  endfunction : per
  // first span may straddle the rate change; only the third is checked
  task automatic meas(input logic [4:0] c);
    int n;
    acc(ADDR_SETUP, {3'b000, c}, 1'b1, 0);
    repeat (3) begin
      @(posedge clk) #1 n = 1;
      while (tick !== 1'b1 && n < 300) begin
        @(posedge clk) #1 n++;
      end
    end
    chk("tick period", 9'(n), 9'(per(c)));
  endtask : meas
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000 fail_count++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(75816));
    repeat (3) @(posedge clk);
    #1 rstn = 1;
    repeat (3) @(posedge clk);
    #1 chk("area start", area_start, 9'h1c3);
    chk("area start small", area_start_s, 9'h0c3);
    acc(ADDR_SETUP, 8'h00, 1'b0, 1);
    chk("setup reset", {1'b0, v}, 9'h000);
    $display("test reset done");
    acc(ADDR_SETUP, 8'h34, 1'b1, 0);
    acc(ADDR_SETUP, 8'h00, 1'b0, 1);
    chk("setup priv", {1'b0, v}, 9'h034);
    chk("area enable", {8'h00, area_en}, 9'h001);
    // unprivileged write only reaches bits 7..5
    acc(ADDR_SETUP, 8'h0b, 1'b0, 0);
    acc(ADDR_SETUP, 8'h00, 1'b1, 1);
    chk("setup nopriv", {1'b0, v}, 9'h014);
    chk("area disable", {8'h00, area_en}, 9'h000);
    pulse_ovf();
    chk("irq masked", {8'h00, irq}, 9'h000);
    acc(ADDR_SETUP, 8'h94, 1'b1, 1);
    chk("flag set", {1'b0, v}, 9'h054);
    acc(ADDR_SETUP, 8'hd4, 1'b1, 0);
    chk("irq on", {8'h00, irq}, 9'h001);
    acc(ADDR_SETUP, 8'h00, 1'b1, 1);
    chk("flag kept", {1'b0, v}, 9'h0d4);
    acc(ADDR_SETUP, 8'h94, 1'b0, 0);
    chk("irq off", {8'h00, irq}, 9'h000);
    acc(ADDR_SETUP, 8'h00, 1'b1, 1);
    chk("flag cleared", {1'b0, v}, 9'h094);
    $display("test overflow done");
    repeat (12) begin
      w = 8'($urandom);
      if (w[5:2] > 4'ha) w[5] = 1'b0;
      acc(ADDR_START, w, 1'($urandom), 0);
      acc(ADDR_START, 8'h00, 1'b0, 1);
      chk("start read", {1'b0, v}, {1'b0, w & 8'hbc});
      chk("area start", area_start, {1'b1, w | 8'hc3});
      chk("area start small", area_start_s, {1'b0, w | 8'hc3});
      chk("area irq en", {8'h00, area_irq_en}, {8'h00, w[7]});
    end
    $display("test start done");
    acc(ADDR_RSVD, 8'h00, 1'b1, 1);
    chk("reserved read", {1'b0, v}, 9'h000);
    acc(16'h1050, 8'h00, 1'b1, 1);
    chk("outside frame", {1'b0, v}, 9'h000);
    acc(16'h1140, 8'h00, 1'b1, 1);
    chk("frame alias", {1'b0, v}, 9'h000);
    $display("test unmapped done");
    acc(ADDR_SETUP, 8'ha4, 1'b1, 0);
    acc(ADDR_START, 8'ha8, 1'b1, 0);
    pulse_ovf();
    chk("irq live", {8'h00, irq}, 9'h001);
    // mid-run reset must drop flag, enables and start code
    @(posedge clk) #1 rstn = 0;
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    repeat (3) @(posedge clk);
    #1 chk("irq after reset", {8'h00, irq}, 9'h000);
    chk("area after reset", {8'h00, area_en}, 9'h000);
    chk("area irq after reset", {8'h00, area_irq_en}, 9'h000);
    chk("start after reset", area_start, 9'h1c3);
    acc(ADDR_SETUP, 8'h00, 1'b0, 1);
    chk("setup after reset", {1'b0, v}, 9'h000);
    $display("test midrun reset done");
    for (int c = 0; c < 32; c++) meas(5'(c));
    $display("test timebase done");
    tally_and_finish;
  end
endmodule : tmsr_setup_regs_tb
